// ---- smac_chk_assertions.sv ----
// Purpose: Port checks for the configuration block
// Assumes: Single core clock domain
// Notes:   Monitor timing accepts either phase of the reference tick
`timescale 1ns/10ps
`default_nettype none

module smac_chk (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       combined_wait_flag,
	input wire logic       monitor_out_a,
	input wire logic       power_save_mode,
	input wire logic       chan_a_drive_en,
	input wire logic       reverse_turn,
	input wire logic       forward_turn,
	input wire logic       chan_a_step,
	input wire logic       pulse_gate_flag,
	input wire logic       pulse_present_flag,
	input wire logic       checksum_ok,
	input wire logic [4:0] current_code_setting,
	input wire logic [7:0] current_ref_mv,
	input wire logic       ref_tick
);
	// ***********************************************
	// Properties
	// ***********************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_DIR: assert property (forward_turn != reverse_turn)
		else $error("turn outputs agree");
	AST_PS: assert property (power_save_mode |-> !chan_a_drive_en)
		else $error("outputs drive in power save");
	AST_CUR: assert property (current_code_setting >= 5'h0b &&
		current_ref_mv == 8'h32 + (8'(current_code_setting) - 8'h0b) * 8'h0a)
		else $error("current setting wrong");
	AST_START: assert property ($fell(combined_wait_flag) && pulse_present_flag &&
		checksum_ok && !power_save_mode |=> pulse_gate_flag)
		else $error("burst did not start");
	AST_STEP: assert property (chan_a_step |-> $past(pulse_gate_flag))
		else $error("step outside gate");
	AST_GAP: assert property (chan_a_step |=> !chan_a_step)
		else $error("steps back to back");
	AST_TICK: assert property (ref_tick |=> !ref_tick)
		else $error("reference tick too fast");
	AST_BAD: assert property ($fell(checksum_ok) |-> ##[0:1] !pulse_gate_flag)
		else $error("burst kept after bad frame");
	AST_MON: assert property ($changed(monitor_out_a) |-> $past(ref_tick) || ref_tick)
		else $error("monitor changed off tick");
endmodule : smac_chk

bind smac_top smac_chk chk_u (.core_clk, .rst, .combined_wait_flag, .monitor_out_a, .power_save_mode,
	.chan_a_drive_en, .reverse_turn, .forward_turn, .chan_a_step, .pulse_gate_flag, .pulse_present_flag,
	.checksum_ok, .current_code_setting, .current_ref_mv, .ref_tick);

`default_nettype wire

// ---- smac_host.sv ----
// Purpose: Host model that shifts configuration frames into the block
// Assumes: Four core cycles per serial clock phase, latch idles high
// Notes:   Serial clock stands low between frames; data line flips when idle
`timescale 1ns/10ps
`default_nettype none

module smac_host (
	input  wire logic core_clk,
	output var logic  ser_clk,
	output var logic  ser_data,
	output var logic  ser_latch
);
	// ***********************************************
	// Frame shifter
	// ***********************************************
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_latch = 1'b1;
	end

	task automatic send(input logic [103:0] f);
		@(posedge core_clk);
		for (int i = 0; i < 104; i++) begin
			ser_clk <= 1'b0;
			ser_data <= f[i];
			repeat (4) @(posedge core_clk);
			ser_clk <= 1'b1;
			repeat (4) @(posedge core_clk);
		end
		ser_clk <= 1'b0;
		// No pull on the data line, so an idle value must not look valid
		ser_data <= ~f[103];
		ser_latch <= 1'b0;
		repeat (4) @(posedge core_clk);
		ser_latch <= 1'b1;
		repeat (8) @(posedge core_clk);
	endtask : send
endmodule : smac_host

`default_nettype wire

// ---- smac_pkg.sv ----
// Purpose: Shared constants for the monitor-select and channel A configuration block
// Assumes: 20 MHz core clock, 4.5 MHz reference rate made as an enable pulse
// Notes:   Frame is 13 bytes shifted LSB first; bytes 4 to 8 are decoded here
//
// Behaviour
// - Byte 4 bits 0-6 select signals shown on monitor pins A and B.
// - Bits 6..2 route enable, rotation, pulse, presence, gate of each channel.
// - Bit 1 routes checksum / combined wait; bit 0 routes chopping / first wait.
// - Several selected signals on one pin are ORed together.
// - Monitored enable is high while channel outputs conduct.
// - Monitored rotation is high for reverse, low for forward.
// - Presence flag is high for the latch cycle when pulse count is nonzero.
// - Gate flag is high while output pulses are being generated.
// - Combined wait flag covers first wait plus magnetize wait.
// - First wait flag is high only during the first wait interval.
// - Checksum status high for a good frame, low after a checksum error.
// - Byte 4 bit 7 one gives normal mode, zero gives power save.
// - Byte 5 holds enable bit 7, rotation bit 6, current bits 0-4; bit 5 ignored.
// - Enable zero floats outputs but step counter still advances.
// - Rotation zero steps forward, one steps reverse.
// - Current codes 11-31 give 50-250 mV in 10 mV; 0-10 clamp to 50 mV.
// - Byte 6 times four gives pulses per frame sync period, up to 1020.
// - Pulses are generated from the falling edge of the combined wait flag.
// - Byte 7 is the low half, byte 8 the high half of the pulse cycle.
// - A checksum failure inhibits stepping and holds checksum monitor low.

package smac_pkg;

	// ***********************************************************
	// Frame layout
	// ***********************************************************
	localparam int unsigned FRAME_BYTES  = 13;
	localparam int unsigned FRAME_BITS   = FRAME_BYTES * 8;
	localparam int unsigned BYTE_MONSEL  = 3;
	localparam int unsigned BYTE_CHA_CFG = 4;
	localparam int unsigned BYTE_CHA_CNT = 5;
	localparam int unsigned BYTE_CYC_LO  = 6;
	localparam int unsigned BYTE_CYC_HI  = 7;

	// ***********************************************************
	// Field positions
	// ***********************************************************
	localparam int unsigned MON_RUN_BIT  = 7;
	localparam int unsigned CFG_EN_BIT   = 7;
	localparam int unsigned CFG_REV_BIT  = 6;
	localparam int unsigned SEL_ENABLE   = 6;
	localparam int unsigned SEL_ROTATE   = 5;
	localparam int unsigned SEL_PULSE    = 4;
	localparam int unsigned SEL_PRESENT  = 3;
	localparam int unsigned SEL_GATE     = 2;
	localparam int unsigned SEL_STATUS   = 1;
	localparam int unsigned SEL_WAVE     = 0;
	localparam int unsigned PULSE_SHIFT  = 2;

	// ***********************************************************
	// Current setting
	// ***********************************************************
	localparam logic [4:0] CUR_CODE_MIN  = 5'h0b;
	localparam logic [7:0] CUR_MV_MIN    = 8'h32;
	localparam logic [7:0] CUR_MV_STEP   = 8'h0a;

	// ***********************************************************
	// Reference rate from the core clock
	// ***********************************************************
	localparam int unsigned CORE_HZ      = 20_000_000;
	localparam int unsigned REF_HZ       = 4_500_000;
	localparam int unsigned RATE_GCD     = 500_000;
	localparam logic [5:0]  ACC_STEP     = 6'(REF_HZ / RATE_GCD);
	localparam logic [5:0]  ACC_MOD      = 6'(CORE_HZ / RATE_GCD);

	// ***********************************************************
	// Values after reset
	// ***********************************************************
	localparam logic [6:0]  RST_SEL      = 7'h00;
	localparam logic        RST_RUN      = 1'b1;
	localparam logic [15:0] RST_CYCLE    = 16'h0001;
	localparam logic        RST_SUM_OK   = 1'b1;

endpackage : smac_pkg

// ---- smac_top.sv ----
// Purpose: Serial frame intake, channel A setup, pulse generation and monitor pins
// Assumes: Serial pins are asynchronous; channel B, wait and chopping signals come
//          from logic on core_clk
// Notes:   Serial clock must run below a quarter of core_clk for clean sampling
`timescale 1ns/10ps
`default_nettype none

module smac_top (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ser_clk,
	input  wire logic        ser_data,
	input  wire logic        ser_latch,
	input  wire logic        first_wait_flag,
	input  wire logic        combined_wait_flag,
	input  wire logic        chop_wave,
	input  wire logic        chan_b_enable,
	input  wire logic        chan_b_reverse,
	input  wire logic        chan_b_pulse,
	input  wire logic        chan_b_present,
	input  wire logic        chan_b_gate,
	output logic             monitor_out_a,
	output logic             monitor_out_b,
	output logic             power_save_mode,
	output logic             chan_a_drive_en,
	output logic             reverse_turn,
	output logic             forward_turn,
	output logic             chan_a_step,
	output logic             pulse_gate_flag,
	output logic             pulse_present_flag,
	output logic             checksum_ok,
	output logic [4:0]       current_code_setting,
	output logic [7:0]       current_ref_mv,
	output logic             ref_tick
);

	// ***********************************************************
	// State
	// ***********************************************************
	typedef struct packed {
		logic                               sclk_s1;
		logic                               sclk_s2;
		logic                               sclk_q;
		logic                               sdat_s1;
		logic                               sdat_s2;
		logic                               lat_s1;
		logic                               lat_s2;
		logic                               lat_q;
		logic [smac_pkg::FRAME_BITS-1:0]    shift;
		logic [6:0]                         sel;
		logic                               run;
		logic                               en;
		logic                               rev;
		logic [4:0]                         cur;
		logic [7:0]                         cnt;
		logic [15:0]                        cyc;
		logic                               sum_ok;
		logic [5:0]                         acc;
		logic                               tick;
		logic                               cwait_q;
		logic [9:0]                         remain;
		logic [15:0]                        cyc_cnt;
		logic                               pulse;
		logic                               mon_a;
		logic                               mon_b;
	} smac_state_t;

	smac_state_t state_r;
	smac_state_t state_nxt;

	// ***********************************************************
	// Helpers
	// ***********************************************************
	function automatic logic [7:0] smac_byte(
		input logic [smac_pkg::FRAME_BITS-1:0] frame,
		input int unsigned                     idx
	);
		smac_byte = frame[idx*8 +: 8];
	endfunction : smac_byte

	function automatic logic smac_sum_zero(input logic [smac_pkg::FRAME_BITS-1:0] frame);
		logic [7:0] sum;
		sum = 8'h00;
		for (int unsigned i = 0; i < smac_pkg::FRAME_BYTES; i++) begin
			sum = sum + smac_byte(frame, i);
		end
		smac_sum_zero = (sum == 8'h00);
	endfunction : smac_sum_zero

	function automatic logic [4:0] smac_clamp(input logic [4:0] code);
		smac_clamp = (code < smac_pkg::CUR_CODE_MIN) ? smac_pkg::CUR_CODE_MIN : code;
	endfunction : smac_clamp

	// ***********************************************************
	// Derived terms
	// ***********************************************************
	logic        sclk_rise;
	logic        lat_fall;
	logic        cwait_fall;
	logic        frame_good;
	logic        drive_en;
	logic        present;
	logic        gate;
	logic [4:0]  cur_eff;
	logic [15:0] period;
	logic [5:0]  acc_sum;
	// Frame bytes are named here because a part-select of a function call is not legal
	logic [7:0]  byte_mon;
	logic [7:0]  byte_cfg;
	logic [7:0]  byte_cnt;
	logic [7:0]  byte_lo;
	logic [7:0]  byte_hi;

	assign byte_mon   = smac_byte(state_r.shift, smac_pkg::BYTE_MONSEL);
	assign byte_cfg   = smac_byte(state_r.shift, smac_pkg::BYTE_CHA_CFG);
	assign byte_cnt   = smac_byte(state_r.shift, smac_pkg::BYTE_CHA_CNT);
	assign byte_lo    = smac_byte(state_r.shift, smac_pkg::BYTE_CYC_LO);
	assign byte_hi    = smac_byte(state_r.shift, smac_pkg::BYTE_CYC_HI);

	assign sclk_rise  = state_r.sclk_s2 & ~state_r.sclk_q;
	assign lat_fall   = ~state_r.lat_s2 & state_r.lat_q;
	assign cwait_fall = ~combined_wait_flag & state_r.cwait_q;
	assign frame_good = smac_sum_zero(state_r.shift);
	assign drive_en   = state_r.en & state_r.run;
	assign present    = (state_r.cnt != 8'h00);
	assign gate       = (state_r.remain != 10'h000);
	assign cur_eff    = smac_clamp(state_r.cur);
	// A zero cycle value is outside the legal range; it runs as the shortest cycle
	assign period     = (state_r.cyc == 16'h0000) ? 16'h0001 : state_r.cyc;
	assign acc_sum    = state_r.acc + smac_pkg::ACC_STEP;

	// ***********************************************************
	// Next state
	// ***********************************************************
	always_comb begin
		state_nxt = state_r;

		// Two flops on every serial pin before any logic looks at it
		state_nxt.sclk_s1 = ser_clk;
		state_nxt.sclk_s2 = state_r.sclk_s1;
		state_nxt.sclk_q  = state_r.sclk_s2;
		state_nxt.sdat_s1 = ser_data;
		state_nxt.sdat_s2 = state_r.sdat_s1;
		state_nxt.lat_s1  = ser_latch;
		state_nxt.lat_s2  = state_r.lat_s1;
		state_nxt.lat_q   = state_r.lat_s2;

		// LSB first: new bits enter at the top, so after 104 shifts
		// bit zero of byte one rests at index zero
		if (sclk_rise) begin
			state_nxt.shift = {state_r.sdat_s2, state_r.shift[smac_pkg::FRAME_BITS-1:1]};
		end

		// Frame is taken on the latch falling edge; a bad frame leaves the
		// previous setup in force so the motor is not driven by corrupt data
		if (lat_fall) begin
			state_nxt.sum_ok = frame_good;
			if (frame_good) begin
				state_nxt.sel = byte_mon[6:0];
				state_nxt.run = byte_mon[smac_pkg::MON_RUN_BIT];
				state_nxt.en  = byte_cfg[smac_pkg::CFG_EN_BIT];
				state_nxt.rev = byte_cfg[smac_pkg::CFG_REV_BIT];
				state_nxt.cur = byte_cfg[4:0];
				state_nxt.cnt = byte_cnt;
				state_nxt.cyc = {byte_hi, byte_lo};
			end
		end

		// Fractional divider: 9 of every 40 core cycles carry a reference tick
		state_nxt.tick = 1'b0;
		if (acc_sum >= smac_pkg::ACC_MOD) begin
			state_nxt.acc  = acc_sum - smac_pkg::ACC_MOD;
			state_nxt.tick = 1'b1;
		end else begin
			state_nxt.acc = acc_sum;
		end

		// Pulse burst starts when both waits are over
		state_nxt.cwait_q = combined_wait_flag;
		state_nxt.pulse   = 1'b0;
		if (!state_r.sum_ok || !state_r.run) begin
			state_nxt.remain  = 10'h000;
			state_nxt.cyc_cnt = 16'h0000;
		end else if (cwait_fall) begin
			state_nxt.remain  = {state_r.cnt, 2'b00};
			state_nxt.cyc_cnt = 16'h0000;
		end else if (gate && state_r.tick) begin
			// One count per reference period; steps advance even when floating
			if (state_r.cyc_cnt + 16'h0001 >= period) begin
				state_nxt.cyc_cnt = 16'h0000;
				state_nxt.pulse   = 1'b1;
				state_nxt.remain  = state_r.remain - 10'h001;
			end else begin
				state_nxt.cyc_cnt = state_r.cyc_cnt + 16'h0001;
			end
		end

		// Monitor pins only move on a reference tick so the OR never glitches
		if (state_r.tick) begin
			state_nxt.mon_a =
				(state_r.sel[smac_pkg::SEL_ENABLE]  & drive_en)        |
				(state_r.sel[smac_pkg::SEL_ROTATE]  & state_r.rev)     |
				(state_r.sel[smac_pkg::SEL_PULSE]   & state_r.pulse)   |
				(state_r.sel[smac_pkg::SEL_PRESENT] & present)         |
				(state_r.sel[smac_pkg::SEL_GATE]    & gate)            |
				(state_r.sel[smac_pkg::SEL_STATUS]  & state_r.sum_ok)  |
				(state_r.sel[smac_pkg::SEL_WAVE]    & chop_wave);
			state_nxt.mon_b =
				(state_r.sel[smac_pkg::SEL_ENABLE]  & chan_b_enable)   |
				(state_r.sel[smac_pkg::SEL_ROTATE]  & chan_b_reverse)  |
				(state_r.sel[smac_pkg::SEL_PULSE]   & chan_b_pulse)    |
				(state_r.sel[smac_pkg::SEL_PRESENT] & chan_b_present)  |
				(state_r.sel[smac_pkg::SEL_GATE]    & chan_b_gate)     |
				(state_r.sel[smac_pkg::SEL_STATUS]  & combined_wait_flag) |
				(state_r.sel[smac_pkg::SEL_WAVE]    & first_wait_flag);
		end
	end

	// ***********************************************************
	// Registers
	// ***********************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r         <= '0;
			state_r.sel     <= smac_pkg::RST_SEL;
			state_r.run     <= smac_pkg::RST_RUN;
			state_r.cyc     <= smac_pkg::RST_CYCLE;
			state_r.sum_ok  <= smac_pkg::RST_SUM_OK;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ***********************************************************
	// Outputs
	// ***********************************************************
	assign monitor_out_a        = state_r.mon_a;
	assign monitor_out_b        = state_r.mon_b;
	assign power_save_mode      = ~state_r.run;
	assign chan_a_drive_en      = drive_en;
	assign reverse_turn         = state_r.rev;
	assign forward_turn         = ~state_r.rev;
	assign chan_a_step          = state_r.pulse;
	assign pulse_gate_flag      = gate;
	assign pulse_present_flag   = present;
	assign checksum_ok          = state_r.sum_ok;
	assign current_code_setting = cur_eff;
	assign current_ref_mv       = smac_pkg::CUR_MV_MIN +
		8'((cur_eff - smac_pkg::CUR_CODE_MIN) * smac_pkg::CUR_MV_STEP);
	assign ref_tick             = state_r.tick;

endmodule : smac_top

`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the configuration block
// Assumes: Host model shifts frames; one vector drives wait and channel B levels
// Notes:   Monitor pins are read well after a tick has passed
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic       core_clk;
	logic       rst;
	logic [6:0] bs;
	logic       ma, mb, ps, den, rev, fwd, stp, gate, pres, ok, tick;
	logic [4:0] code;
	logic [7:0] mv;
	wire        ser_clk, ser_data, ser_latch;
	int         bad_count, cmp_count;

	smac_host host_u (.core_clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));
	smac_top dut_u (.core_clk(core_clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
		.ser_latch(ser_latch), .first_wait_flag(bs[0]), .combined_wait_flag(bs[1]), .chop_wave(bs[0]),
		.chan_b_enable(bs[6]), .chan_b_reverse(bs[5]), .chan_b_pulse(bs[4]), .chan_b_present(bs[3]),
		.chan_b_gate(bs[2]), .monitor_out_a(ma), .monitor_out_b(mb), .power_save_mode(ps),
		.chan_a_drive_en(den), .reverse_turn(rev), .forward_turn(fwd), .chan_a_step(stp),
		.pulse_gate_flag(gate), .pulse_present_flag(pres), .checksum_ok(ok),
		.current_code_setting(code), .current_ref_mv(mv), .ref_tick(tick));

	// ***********************************************
	// Helpers
	// ***********************************************
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic frame(input logic [7:0] b4, b5, b6, b7, b8, input logic bad);
		logic [7:0]   b [13];
		logic [7:0]   s;
		logic [103:0] f;
		b = '{8'h01, 8'h01, 8'h00, b4, b5, b6, b7, b8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		s = 8'h00;
		for (int i = 0; i < 12; i++) s += b[i];
		b[12] = (8'h00 - s) ^ {7'h00, bad};
		for (int i = 0; i < 13; i++) f[i*8 +: 8] = b[i];
		host_u.send(f);
	endtask : frame

	task automatic kick();
		@(posedge core_clk) bs <= 7'h02;
		repeat (5) @(posedge core_clk);
		bs <= 7'h00;
	endtask : kick

	task automatic steps(input int len, output int n, output int gap);
		int last;
		n = 0;
		gap = 0;
		last = 0;
		for (int i = 0; i < len; i++) begin
			@(posedge core_clk);
			#1;
			if (stp === 1'b1) begin
				n++;
				if (n == 3) gap = i - last;
				last = i;
			end
		end
	endtask : steps

	// ***********************************************
	// Scenarios
	// ***********************************************
	task automatic t_cfg();
		logic [4:0] c [4];
		logic [4:0] e;
		c = '{5'h00, 5'h0a, 5'h0b, 5'h1f};
		for (int i = 0; i < 4; i++) begin
			frame(8'h80, {1'b1, 1'(i), 1'b1, c[i]}, 8'h00, 8'h01, 8'h00, 1'b0);
			e = (c[i] < 5'h0b) ? 5'h0b : c[i];
			chk("code", 8'(e), 8'(code));
			chk("mv", 8'h32 + (8'(e) - 8'h0b) * 8'h0a, mv);
			chk("rev", 8'(i % 2), 8'(rev));
			chk("drive", 8'h01, 8'(den));
			chk("present", 8'h00, 8'(pres));
		end
		$display("config test done");
	endtask : t_cfg

	task automatic t_burst();
		int n;
		int gap;
		frame(8'h80, 8'h00, 8'h01, 8'h02, 8'h01, 1'b0);
		chk("present", 8'h01, 8'(pres));
		chk("drive", 8'h00, 8'(den));
		kick();
		steps(6000, n, gap);
		chk("steps", 8'h04, 8'(n));
		chk("gap", 8'h01, 8'(gap inside {[1144:1149]}));
		chk("gate", 8'h00, 8'(gate));
		$display("burst test done");
	endtask : t_burst

	task automatic t_bad();
		int n;
		int gap;
		kick();
		frame(8'h80, 8'h80, 8'h01, 8'h02, 8'h01, 1'b1);
		chk("sum", 8'h00, 8'(ok));
		chk("kept", 8'h00, 8'(den));
		steps(3000, n, gap);
		chk("stopped", 8'h00, 8'(n));
		frame(8'h00, 8'h80, 8'h00, 8'h01, 8'h00, 1'b0);
		chk("sum", 8'h01, 8'(ok));
		chk("ps", 8'h01, 8'(ps));
		chk("drive", 8'h00, 8'(den));
		$display("checksum test done");
	endtask : t_bad

	task automatic t_mon();
		logic [6:0] a;
		a = 7'b1100011;
		for (int k = 0; k < 8; k++) begin
			frame({1'b1, (k == 7) ? 7'h7f : 7'(1 << k)}, 8'hc0, 8'h00, 8'h01, 8'h00, 1'b0);
			for (int p = 0; p < 2; p++) begin
				@(posedge core_clk) bs <= (k == 7) ? 7'h00 : (p == 1) ? 7'(1 << k) : ~7'(1 << k);
				repeat (20) @(posedge core_clk);
				chk("mon_b", 8'((k != 7) && (p == 1)), 8'(mb));
				chk("mon_a", 8'((k == 7) || ((k == 0) ? (p == 1) : a[k])), 8'(ma));
			end
		end
		$display("monitor test done");
	endtask : t_mon

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		bad_count++;
		conclude();
	end

	initial begin
		rst = 1'b1;
		bs = 7'h00;
		bad_count = 0;
		cmp_count = 0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("fwd", 8'h01, 8'(fwd));
		chk("sum", 8'h01, 8'(ok));
		t_cfg();
		t_burst();
		t_bad();
		t_mon();
		conclude();
	end
endmodule : testbench

`default_nettype wire
